// ===== hdl/tsmc_multiplex_control.sv
// Purpose: Station addressing, manual and reset control plus data buffer
// Assumes: Station pins are asynchronous; processor strobes are on clock
// Notes: Register updates take one clock after the write strobe
// Notes on behaviour
// - Bits 1:0 hold the selected station address, read and write.
// - Each register write pulses start set, clearing the stop flag.
// - Address decodes to one head enable per station.
// - Bits 5:2 latch station start requests until serviced.
// - Start set with a station's enable clears that station's request.
// - Bits 9:6 show manual mode; manual output driven high too.
// - Bits 13:10 latch station reset switch presses.
// - Reset press on the on-line station pulses short bus reset.
// - Selecting a station by writing its address clears its reset bit.
// - CPU reset clears address and all latched bits.
// - Address change pulses analog reset clearing converter registers.
// - Rewriting the same address gives no analog reset.
// - Held advance in manual on line gives 3 Hz start requests.
// - Processor write or gate short-to-instr drives short bus; write follows.
// - Processor read or gate instr-to-short drives processor bus; read follows.
`timescale 1ns/1ps
module tsmc_multiplex_control #(
   parameter int unsigned ADVANCE_PERIOD = tsmc_pkg::ADVANCE_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Processor side bus
   input wire logic [tsmc_pkg::BUS_W-1:0] proc_bus_wdata,
   input wire logic proc_bus_write,
   input wire logic proc_bus_read,
   input wire logic gate_short_to_instr,
   input wire logic gate_instr_to_short,
   input wire logic station_control_sel,
   output logic [tsmc_pkg::BUS_W-1:0] proc_bus_rdata,
   output logic proc_bus_rdata_oe_n,
   // Short register bus
   input wire logic [tsmc_pkg::BUS_W-1:0] short_bus_rdata,
   output tsmc_pkg::tsmc_short_bus_t short_bus,
   output logic short_bus_data_oe_n,
   // Stations
   input wire tsmc_pkg::tsmc_station_in_t station_in,
   output logic [tsmc_pkg::NUM_STATIONS-1:0] head_enable,
   output logic [tsmc_pkg::NUM_STATIONS-1:0] station_manual,
   // Side effects
   output logic start_set_pulse_n,
   output logic short_bus_reset_n,
   output logic analog_reset
);

   localparam int unsigned NS = tsmc_pkg::NUM_STATIONS;

   typedef struct packed {
      tsmc_pkg::tsmc_station_in_t sync1;
      tsmc_pkg::tsmc_station_in_t sync2;
      logic [NS-1:0] reset_prev;
      logic [1:0] addr;
      logic [NS-1:0] start_req;
      logic [NS-1:0] manual;
      logic [NS-1:0] reset_lat;
      logic start_set;
      logic short_reset;
      logic anlg_reset;
      logic [tsmc_pkg::BUS_W-1:0] rdata;
      logic [tsmc_pkg::BUS_W-1:0] sdata;
      logic short_bus_write_n;
      logic short_bus_read_n;
   } tsmc_state_t;

   tsmc_state_t st_r;
   tsmc_state_t st_nxt;
   logic [NS-1:0] adv_pulse;
   logic [NS-1:0] adv_enable;
   logic ctrl_write;
   logic [NS-1:0] enable_dec;
   logic [NS-1:0] new_enable;
   logic [tsmc_pkg::CTRL_W-1:0] ctrl_read;

   ////////////////////////////////////////////////////////////////////////////
   // Advance dividers, one per station

   genvar gi;
   generate
      for (gi = 0; gi < NS; gi++) begin : g_adv
         assign adv_enable[gi] = st_r.manual[gi] & enable_dec[gi]
                                 & ~st_r.sync2.advance_request_n[gi];
         tsmc_advance_divider #(
            .PERIOD(ADVANCE_PERIOD)
         ) u_div (
            .clock(clock),
            .sys_rst(sys_rst),
            .enable(adv_enable[gi]),
            .advance_pulse_train(adv_pulse[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Decode and register read image

   assign ctrl_write = proc_bus_write & station_control_sel;

   always_comb begin
      enable_dec = '0;
      enable_dec[st_r.addr] = 1'b1;
      new_enable = '0;
      new_enable[proc_bus_wdata[tsmc_pkg::ADDR_LSB +: tsmc_pkg::ADDR_W]] = 1'b1;
      ctrl_read = '0;
      ctrl_read[tsmc_pkg::ADDR_LSB +: tsmc_pkg::ADDR_W] = st_r.addr;
      ctrl_read[tsmc_pkg::START_LSB +: NS] = st_r.start_req;
      ctrl_read[tsmc_pkg::MANUAL_LSB +: NS] = st_r.manual;
      ctrl_read[tsmc_pkg::RESET_LSB +: NS] = st_r.reset_lat;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [NS-1:0] rst_edge;
      rst_edge = '0;
      st_nxt = st_r;
      st_nxt.sync1 = station_in;
      st_nxt.sync2 = st_r.sync1;
      st_nxt.reset_prev = st_r.sync2.reset_switch;
      rst_edge = st_r.sync2.reset_switch & ~st_r.reset_prev;
      st_nxt.manual = st_r.sync2.manual_mode;
      st_nxt.start_set = ctrl_write;
      st_nxt.anlg_reset = 1'b0;
      st_nxt.short_reset = 1'b0;
      if (ctrl_write) begin
         st_nxt.addr = proc_bus_wdata[tsmc_pkg::ADDR_LSB +: tsmc_pkg::ADDR_W];
         st_nxt.anlg_reset = (st_nxt.addr != st_r.addr);
         st_nxt.start_req = st_r.start_req & ~new_enable;
         st_nxt.reset_lat = st_r.reset_lat & ~new_enable;
      end
      st_nxt.start_req = st_nxt.start_req | st_r.sync2.start_request | adv_pulse;
      st_nxt.reset_lat = st_nxt.reset_lat | rst_edge;
      st_nxt.short_reset = |(rst_edge & enable_dec);
      st_nxt.short_bus_write_n = proc_bus_write | gate_short_to_instr;
      st_nxt.sdata = proc_bus_wdata;
      st_nxt.short_bus_read_n = proc_bus_read | gate_instr_to_short;
      st_nxt.rdata = station_control_sel
                     ? {{(tsmc_pkg::BUS_W - tsmc_pkg::CTRL_W){1'b0}}, ctrl_read}
                     : short_bus_rdata;
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
         st_r.addr <= tsmc_pkg::ADDR_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign head_enable = enable_dec;
   assign station_manual = st_r.manual;
   assign start_set_pulse_n = ~st_r.start_set;
   assign short_bus_reset_n = ~st_r.short_reset;
   assign analog_reset = st_r.anlg_reset;
   assign short_bus.data = st_r.sdata;
   assign short_bus.write_n = ~st_r.short_bus_write_n;
   assign short_bus.read_n = ~st_r.short_bus_read_n;
   assign short_bus_data_oe_n = ~st_r.short_bus_write_n;
   assign proc_bus_rdata = st_r.rdata;
   assign proc_bus_rdata_oe_n = ~st_r.short_bus_read_n;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_start_set_write: assert property (@(posedge clock) disable iff (sys_rst)
      ctrl_write |=> !start_set_pulse_n) else $error("no start set after write");
   a_addr_stored: assert property (@(posedge clock) disable iff (sys_rst)
      ctrl_write |=> (st_r.addr == $past(proc_bus_wdata[1:0])))
      else $error("address not stored");
   a_head_onehot: assert property (@(posedge clock) disable iff (sys_rst)
      $onehot(head_enable) && head_enable[st_r.addr]) else $error("bad head enable");
   a_head_select: assert property (@(posedge clock) disable iff (sys_rst)
      ctrl_write |=> (head_enable == ({{(NS-1){1'b0}}, 1'b1} << $past(proc_bus_wdata[1:0]))))
      else $error("head enable not selected");
   a_reset_clear: assert property (@(posedge clock) disable iff (sys_rst)
      (ctrl_write && !(st_r.sync2.reset_switch[proc_bus_wdata[1:0]]
       && !st_r.reset_prev[proc_bus_wdata[1:0]]))
      |=> !st_r.reset_lat[st_r.addr]) else $error("reset bit not cleared");
   a_start_clear: assert property (@(posedge clock) disable iff (sys_rst)
      (ctrl_write && !st_r.sync2.start_request[proc_bus_wdata[1:0]]
       && !adv_pulse[proc_bus_wdata[1:0]])
      |=> !st_r.start_req[st_r.addr]) else $error("request not cleared");
   a_start_latch: assert property (@(posedge clock) disable iff (sys_rst)
      st_r.sync2.start_request[0] |=> st_r.start_req[0]) else $error("request lost");
   a_anlg_change: assert property (@(posedge clock) disable iff (sys_rst)
      (ctrl_write && proc_bus_wdata[1:0] != st_r.addr) |=> analog_reset)
      else $error("no analog reset");
   a_anlg_same: assert property (@(posedge clock) disable iff (sys_rst)
      (ctrl_write && proc_bus_wdata[1:0] == st_r.addr) |=> !analog_reset)
      else $error("spurious analog reset");
   a_reset_latch: assert property (@(posedge clock) disable iff (sys_rst)
      (st_r.sync2.reset_switch[1] && !st_r.reset_prev[1]) |=> st_r.reset_lat[1])
      else $error("reset press lost");
   a_short_reset: assert property (@(posedge clock) disable iff (sys_rst)
      (st_r.sync2.reset_switch[st_r.addr] && !st_r.reset_prev[st_r.addr] && !ctrl_write)
      |=> !short_bus_reset_n) else $error("no short reset");
   a_short_bus_write_n_follow: assert property (@(posedge clock) disable iff (sys_rst)
      proc_bus_write |=> !short_bus.write_n) else $error("short write missing");
   a_short_bus_read_n_follow: assert property (@(posedge clock) disable iff (sys_rst)
      gate_instr_to_short |=> !short_bus.read_n) else $error("short read missing");

endmodule : tsmc_multiplex_control

// ===== hdl/tsmc_pkg.sv
// Purpose: Shared constants and carriers for the test station multiplex control
// Assumes: Single 100 MHz clock, asynchronous active-high reset
// Notes: Station control register is reached through the processor bus strobes with station_control_sel
package tsmc_pkg;

   localparam int unsigned NUM_STATIONS = 4;
   localparam int unsigned BUS_W = 24;
   localparam int unsigned CTRL_W = 14;

   // Station control register field positions
   localparam int unsigned ADDR_LSB = 0;
   localparam int unsigned ADDR_W = 2;
   localparam int unsigned START_LSB = 2;
   localparam int unsigned MANUAL_LSB = 6;
   localparam int unsigned RESET_LSB = 10;

   localparam logic [1:0] ADDR_RESET = 2'h0;

   // Advance pulse train: 3 Hz at 100 MHz
   localparam int unsigned CLOCK_HZ = 100_000_000;
   localparam int unsigned ADVANCE_HZ = 3;
   localparam int unsigned ADVANCE_CYCLES = CLOCK_HZ / ADVANCE_HZ;

   typedef struct packed {
      logic [BUS_W-1:0] data;
      logic write_n;
      logic read_n;
   } tsmc_short_bus_t;

   typedef struct packed {
      logic [NUM_STATIONS-1:0] start_request;
      logic [NUM_STATIONS-1:0] manual_mode;
      logic [NUM_STATIONS-1:0] reset_switch;
      logic [NUM_STATIONS-1:0] advance_request_n;
   } tsmc_station_in_t;

endpackage : tsmc_pkg

// ===== hdl/tsmc_advance_divider.sv
// Purpose: Divider making the advance pulse train while the button is held
// Assumes: Enable is already synchronised to clock
// Notes: First pulse comes one period after the hold begins
`timescale 1ns/1ps
module tsmc_advance_divider #(
   parameter int unsigned PERIOD = tsmc_pkg::ADVANCE_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Control
   input wire logic enable,
   output logic advance_pulse_train
);

   typedef struct packed {
      logic [31:0] count;
      logic pulse;
   } tsmc_div_state_t;

   tsmc_div_state_t st_r;
   tsmc_div_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.pulse = 1'b0;
      if (!enable) begin
         st_nxt.count = 32'h0000_0000;
      end else if (st_r.count == 32'(PERIOD - 1)) begin
         st_nxt.count = 32'h0000_0000;
         st_nxt.pulse = 1'b1;
      end else begin
         st_nxt.count = st_r.count + 32'h0000_0001;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign advance_pulse_train = st_r.pulse;

endmodule : tsmc_advance_divider

// ===== testbench/tsmc_station_model.sv
// Purpose: Stations and short bus far side for the multiplex control bench
// Assumes: Driven from the bench at falling clock edges
// Notes: An unread short bus shows a pattern that changes every cycle
`timescale 1ns/1ps
module tsmc_station_model (
   // Clock
   input wire logic clock,
   // Short bus answer request
   input wire logic sb_hold,
   input wire logic [tsmc_pkg::BUS_W-1:0] sb_val,
   // Far side outputs
   output logic [tsmc_pkg::BUS_W-1:0] short_bus_rdata,
   output tsmc_pkg::tsmc_station_in_t station_in
);
   logic [tsmc_pkg::BUS_W-1:0] noise_r = 24'h5a_5a5a;
   always @(negedge clock) noise_r <= {noise_r[22:0], ~noise_r[23]};
   assign short_bus_rdata = sb_hold ? sb_val : noise_r;
   initial station_in = '{default: 4'h0, advance_request_n: 4'hf};
   task set_in(input tsmc_pkg::tsmc_station_in_t v);
      @(negedge clock) station_in = v;
   endtask : set_in
endmodule : tsmc_station_model

// ===== testbench/test_test_station_multiplex_control.sv
// Purpose: Self-checking bench for the station multiplex control
// Assumes: Advance divider shortened to 10 cycles
// Notes: Stimulus at falling edges, outputs sampled one edge after the strobe
`timescale 1ns/1ps
module test_test_station_multiplex_control;
   logic clock = 0, sys_rst = 1, sel = 0, sb_hold = 0, wr = 0, rd = 0, gsi = 0, gis = 0;
   logic [23:0] wdata = 0, sb_val = 0, rdata, sb_rdata, v;
   logic proc_oe_n, sb_oe_n, ssp_n, srst_n, anr;
   logic [3:0] head_en, man_out, start_e = 0, man_e = 0, rst_e = 0, m;
   logic [1:0] addr_e = 0;
   tsmc_pkg::tsmc_short_bus_t sbus;
   tsmc_pkg::tsmc_station_in_t st_in, idle;
   int failures = 0, n_tests = 0, n_srst = 0, cnt;
   tsmc_multiplex_control #(.ADVANCE_PERIOD(10)) u_tsmc_multiplex_control (.clock(clock),
      .sys_rst(sys_rst), .proc_bus_wdata(wdata), .proc_bus_write(wr), .proc_bus_read(rd),
      .gate_short_to_instr(gsi), .gate_instr_to_short(gis), .station_control_sel(sel),
      .proc_bus_rdata(rdata), .proc_bus_rdata_oe_n(proc_oe_n), .short_bus_rdata(sb_rdata),
      .short_bus(sbus), .short_bus_data_oe_n(sb_oe_n), .station_in(st_in),
      .head_enable(head_en), .station_manual(man_out), .start_set_pulse_n(ssp_n),
      .short_bus_reset_n(srst_n), .analog_reset(anr));
   tsmc_station_model u_tsmc_station_model (.clock(clock), .sb_hold(sb_hold),
      .sb_val(sb_val), .short_bus_rdata(sb_rdata), .station_in(st_in));
   initial forever #5 clock = ~clock;
   always @(posedge clock) if (srst_n === 1'b0) n_srst <= n_srst + 1;
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [23:0] ctrl();
      return {10'h0, rst_e, man_e, start_e, addr_e};
   endfunction : ctrl
   task check(input logic [23:0] seen, input logic [23:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Strobes in order write, read, short-to-instr, instr-to-short
   task cyc(input logic [3:0] s, input logic sl, input logic [23:0] d);
      @(negedge clock) {wr, rd, gsi, gis} = s;
      sel = sl;
      wdata = d;
      @(negedge clock) {wr, rd, gsi, gis} = 4'h0;
   endtask : cyc
   task rd_ctrl();
      cyc(4'h4, 1, 0);
      check(rdata, ctrl());
      check(24'(ssp_n), 1);
   endtask : rd_ctrl
   task wr_addr(input logic [1:0] a);
      cyc(4'h8, 1, {22'h0, a});
      check(24'(ssp_n), 0);
      check(24'(anr), 24'(a != addr_e));
      check(24'(head_en), 24'(4'h1 << a));
      addr_e = a;
      start_e[a] = 0;
      rst_e[a] = 0;
      rd_ctrl();
   endtask : wr_addr
   task finish_test();
      $display("failures %0d n_tests %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   initial begin
      #200_000 failures++;
      finish_test();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      idle = '{default: 4'h0, advance_request_n: 4'hf};
      void'($urandom(32'hbdab));
      repeat (4) @(negedge clock);
      sys_rst = 0;
      rd_ctrl();
      check(24'(head_en), 1);
      for (int i = 0; i < 12; i++) wr_addr(i % 4 == 3 ? addr_e : 2'($urandom));
      m = 4'($urandom) | 4'h1;
      u_tsmc_station_model.set_in('{start_request: m, advance_request_n: 4'hf, default: 4'h0});
      repeat (4) @(negedge clock);
      u_tsmc_station_model.set_in(idle);
      repeat (4) @(negedge clock);
      start_e = m;
      rd_ctrl();
      for (int k = 3; k >= 0; k--) if (start_e[k]) wr_addr(2'(k));
      m = 4'($urandom);
      u_tsmc_station_model.set_in('{manual_mode: m, advance_request_n: 4'hf, default: 4'h0});
      repeat (5) @(negedge clock);
      man_e = m;
      rd_ctrl();
      check(24'(man_out), 24'(m));
      // reset switches, on line only for even stations
      for (int k = 0; k < 4; k++) begin
         wr_addr(k % 2 == 0 ? 2'(k) : 2'(k ^ 1));
         cnt = n_srst;
         u_tsmc_station_model.set_in('{reset_switch: 4'h1 << k, manual_mode: man_e,
            advance_request_n: 4'hf, default: 4'h0});
         repeat (5) @(negedge clock);
         u_tsmc_station_model.set_in('{manual_mode: man_e, advance_request_n: 4'hf,
            default: 4'h0});
         repeat (4) @(negedge clock);
         check(24'(n_srst - cnt), 24'(k % 2 == 0));
         rst_e[k] = 1;
         rd_ctrl();
         wr_addr(2'(k));
      end
      wr_addr(2);
      u_tsmc_station_model.set_in('{manual_mode: 4'h4, advance_request_n: 4'hb,
         default: 4'h0});
      repeat (40) @(negedge clock);
      u_tsmc_station_model.set_in(idle);
      repeat (5) @(negedge clock);
      man_e = 0;
      start_e[2] = 1;
      rd_ctrl();
      v = 24'($urandom);
      cyc(4'h8, 0, v);
      check(sbus.data, v);
      check(24'({sbus.write_n, sb_oe_n}), 0);
      cyc(4'h2, 0, 0);
      check(24'(sb_oe_n), 0);
      sb_hold = 1;
      sb_val = ~v;
      cyc(4'h4, 0, 0);
      check(rdata, ~v);
      check(24'({sbus.read_n, proc_oe_n}), 0);
      sb_hold = 0;
      cyc(4'h1, 0, 0);
      check(24'(proc_oe_n), 0);
      wr_addr(3);
      @(negedge clock) sys_rst = 1;
      repeat (2) @(negedge clock);
      sys_rst = 0;
      {addr_e, start_e, rst_e} = 0;
      rd_ctrl();
      check(24'(head_en), 1);
      finish_test();
   end
endmodule : test_test_station_multiplex_control
